// >>> verilog/rss_regs.svh
// register offsets, field positions, reset values and counts of the shift/stamp/calib block
// Operation
// - alarm hour and day fields only count when their mask bit is clear
// - weekday select makes day units a weekday and ignores day tens
// - alarm am/pm flag is compared together with the hour fields
// - write protection key is write-only and always reads zero
// - subsecond readout returns the live synchronous down-counter
// - readout may exceed the divider after a shift; counter keeps it
// - fraction subtract is added to the synchronous counter, delaying the clock
// - new shift writes are ignored while a shift is pending
// - any shift register write clears the shadow synced flag
// - advance one second pulses the calendar forward and reads as zero
// - stamp captures are valid only while stamp flag set; clearing zeroes them
// - stamp event latches counter, time, am/pm, date, month, weekday
// - captured weekday is three bits, zero meaning none
// - calibration suppresses programmed pulses in each 2^20 kernel pulse window
// - sixteen second cycle halves the window and forces count bit 0 low
// - eight second cycle quarters the window and forces count bits 1:0 low
// - insert enable adds one kernel pulse every 2^11 pulses
// - tamper one enabled by bit 0, tamper two by bit 3
// - polarity picks level with filtering, edge without filtering
// - tamper interrupt only raised when tamper irq enable is set
// - filter codes 1,2,3 need 2,4,8 matching samples
// - shift write sets pending flag immediately until shift applied
// - stamp flag set by hardware on event, cleared by writing 0
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
`define RSS_OFF_STATUS 8'h0C
`define RSS_OFF_DIVIDER 8'h10
`define RSS_OFF_ALARM 8'h1C
`define RSS_OFF_WPKEY 8'h24
`define RSS_OFF_FRACTION_COUNTER_READOUT 8'h28
`define RSS_OFF_SHIFT 8'h2C
`define RSS_OFF_TSTIME 8'h30
`define RSS_OFF_TSDATE 8'h34
`define RSS_OFF_TSSUB 8'h38
`define RSS_OFF_CAL 8'h3C
`define RSS_OFF_TAMPER 8'h40
`define RSS_ST_PEND 3
`define RSS_ST_SYNC 5
`define RSS_ST_TS 11
`define RSS_ST_TSOVR 12
`define RSS_ST_TP1 13
`define RSS_SH_ADD 31
`define RSS_CAL_C16 13
`define RSS_CAL_C8 14
`define RSS_CAL_INS 15
`define RSS_TA_EN1 0
`define RSS_TA_POL1 1
`define RSS_TA_IE 2
`define RSS_TA_EN2 3
`define RSS_TA_POL2 4
`define RSS_TA_FLT 11
`define RSS_DIV_RESET 15'h00FF
`define RSS_APRE_RESET 7'h7F
`define RSS_INS_PHASE 11'h7FF
`endif

// >>> verilog/rss_pkg.sv
// types shared by the shift/stamp/calib block
package rss_pkg;
  // live calendar time, same layout as the time registers
  typedef struct packed {
    logic am_pm_flag;
    logic [1:0] hour_t;
    logic [3:0] hour_u;
    logic rsv_m;
    logic [2:0] min_t;
    logic [3:0] min_u;
    logic rsv_s;
    logic [2:0] sec_t;
    logic [3:0] sec_u;
  } rss_time_s;
  // live calendar date, weekday 0 = none, 1..7 = monday..sunday
  typedef struct packed {
    logic [2:0] weekday;
    logic mon_t;
    logic [3:0] mon_u;
    logic [1:0] rsv;
    logic [1:0] day_t;
    logic [3:0] day_u;
  } rss_date_s;
  // alarm a match word
  typedef struct packed {
    logic alarm_day_mask;
    logic weekday_select;
    logic [1:0] day_tens_bcd;
    logic [3:0] day_units_bcd;
    logic alarm_hour_mask;
    logic am_pm_flag;
    logic [1:0] hour_t;
    logic [3:0] hour_u;
    logic min_mask;
    logic [2:0] min_t;
    logic [3:0] min_u;
    logic sec_mask;
    logic [2:0] sec_t;
    logic [3:0] sec_u;
  } rss_alarm_s;
endpackage

// >>> verilog/rss_core.sv
// shift unit, subsecond counter, timestamp, smooth calibration, tamper 1/2, alarm a match
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_core #(
  // kernel pulses per async tick, minus one
  parameter logic [6:0] ASYNC_DIV = `RSS_APRE_RESET
) (
  // clock and backup-domain reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // calendar side
  input wire rss_pkg::rss_time_s cal_time,
  input wire rss_pkg::rss_date_s cal_date,
  input wire logic stamp_trigger,
  output logic second_tick,
  output logic advance_one_second,
  output logic alarm_hit,
  // tamper pins
  input wire logic tamper_input_one,
  input wire logic tamper_input_two,
  output logic tamper_irq
);

  // whole state of the block in one word
  typedef struct packed {
    // bus answer
    logic ack;
    logic [31:0] rdat;
    // software configuration
    rss_pkg::rss_alarm_s alarm;
    logic [14:0] sync_divider_value;
    logic [8:0] suppressed_pulse_count;
    logic sixteen_second_cycle;
    logic eight_second_cycle;
    logic pulse_insert_enable;
    logic [1:0] tp_en;
    logic [1:0] tp_pol;
    logic tamper_irq_enable;
    logic [1:0] tamper_filter_count;
    // prescaler chain and calibration window
    logic [6:0] apre;
    logic [15:0] fraction_counter;
    logic [19:0] win;
    // shift unit
    logic shift_pending_flag;
    logic [14:0] fraction_subtract;
    logic add_pending;
    // status flags
    logic shadow_synced_flag;
    logic stamp_event_flag;
    logic stamp_overrun;
    // timestamp captures, zero while the stamp flag is clear
    rss_pkg::rss_time_s ts_time;
    rss_pkg::rss_date_s ts_date;
    logic [15:0] ts_frac;
    // tamper detection
    logic [1:0] tp_flag;
    logic [1:0] tp_prev;
    logic [1:0][3:0] tp_run;
    // registered pulses and levels for the outputs
    logic sec_tick;
    logic add_sec;
    logic alarm_hit;
    logic irq;
  } rss_state_s;

  // current state and the value it takes at the next clock
  rss_state_s s_ff;
  rss_state_s nxt_s;

  // byte-lane mask from wishbone select
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // bus decode
  logic take;
  logic wr;
  logic [31:0] bmask;
  // tamper pins
  logic [1:0] tp_in;
  // calibration and prescaler step
  logic suppress;
  logic insert;
  logic [1:0] step;
  logic apre_tick;
  logic [8:0] cal_eff;
  logic [19:0] win_pos;
  logic [19:0] win_lim;
  // synchronous counter before a shift is added
  logic [15:0] frac_base;
  // tamper filter length and events
  logic [3:0] need;
  logic [1:0] tp_evt;
  // register words for reads and merged writes
  logic [31:0] rd;
  logic [31:0] st_word;
  logic [31:0] wst;
  // alarm field compares
  logic match_hour;
  logic match_day;
  logic match_low;

  // both tamper pins as one vector, pin one in bit 0
  assign tp_in = {tamper_input_two, tamper_input_one};

  // one process computes every next value; the state register follows below
  always_comb
  begin
    nxt_s = s_ff;
    // a request is taken once; the ack cycle itself is not taken again
    take = wb_cyc_i & wb_stb_i & ~s_ff.ack;
    wr = take & wb_we_i;
    bmask = lane_mask(wb_sel_i);
    nxt_s.ack = take;
    // one-clock pulses fall back to zero unless raised below
    nxt_s.sec_tick = 1'b0;
    nxt_s.add_sec = 1'b0;

    // effective suppress count and window size by cycle length
    // the shorter windows look at fewer window bits and drop a scaled count,
    // so the average rate correction stays the same for all three lengths
    cal_eff = s_ff.suppressed_pulse_count;
    win_pos = s_ff.win;
    win_lim = {11'h000, cal_eff};
    if (s_ff.eight_second_cycle)
    begin
      win_pos = {2'b00, s_ff.win[17:0]};
      win_lim = {13'h0000, cal_eff[8:2]};
    end
    else if (s_ff.sixteen_second_cycle)
    begin
      win_pos = {1'b0, s_ff.win[18:0]};
      win_lim = {12'h000, cal_eff[8:1]};
    end
    // suppressed pulses sit at the start of each window
    // limitation: the dropped pulses come in one burst, not spread out
    suppress = win_pos < win_lim;
    insert = s_ff.pulse_insert_enable & (s_ff.win[10:0] == `RSS_INS_PHASE);
    nxt_s.win = s_ff.win + 20'h0_0001;
    // pulses per clock: 0 dropped, 1 plain, 2 with an inserted pulse;
    // a drop and an insert in one clock cancel out
    unique case ({suppress, insert})
      2'b10: step = 2'd0;
      2'b01: step = 2'd2;
      default: step = 2'd1;
    endcase

    // asynchronous prescaler takes 0, 1 or 2 kernel pulses per clock
    // an insert can step over zero, so the reload keeps the surplus pulse
    apre_tick = {1'b0, s_ff.apre} < {6'h00, step};
    if (apre_tick)
      nxt_s.apre = 7'(({1'b0, ASYNC_DIV} + 8'h01 + {1'b0, s_ff.apre}) - {6'h00, step});
    else
      nxt_s.apre = 7'({1'b0, s_ff.apre} - {6'h00, step});

    // synchronous down-counter; a shift lands on an async tick
    // applying it only on a tick keeps the counter from moving between async ticks
    frac_base = s_ff.fraction_counter;
    if (apre_tick)
    begin
      if (s_ff.fraction_counter == 16'h0000)
      begin
        frac_base = {1'b0, s_ff.sync_divider_value};
        nxt_s.sec_tick = 1'b1;
      end
      else
        frac_base = s_ff.fraction_counter - 16'h0001;
    end
    nxt_s.fraction_counter = frac_base;
    if (apre_tick & s_ff.shift_pending_flag)
    begin
      // counter may land above the divider; it just counts down from there
      nxt_s.fraction_counter = frac_base + {1'b0, s_ff.fraction_subtract};
      nxt_s.add_sec = s_ff.add_pending;
      nxt_s.shift_pending_flag = 1'b0;
      nxt_s.add_pending = 1'b0;
    end

    // tamper detection, both inputs alike
    // edge mode compares against last clock's sample; level mode counts
    // matching samples and fires once, when the run reaches the filter length
    // the run counter saturates so a long level never wraps into a second event
    unique case (s_ff.tamper_filter_count)
      2'd1: need = 4'd2;
      2'd2: need = 4'd4;
      2'd3: need = 4'd8;
      default: need = 4'd0;
    endcase
    for (int i = 0; i < 2; i++)
    begin
      nxt_s.tp_prev[i] = tp_in[i];
      tp_evt[i] = 1'b0;
      if (tp_in[i] == s_ff.tp_pol[i])
        nxt_s.tp_run[i] = (s_ff.tp_run[i] == 4'hF) ? 4'hF : s_ff.tp_run[i] + 4'h1;
      else
        nxt_s.tp_run[i] = 4'h0;
      if (s_ff.tp_en[i])
      begin
        if (s_ff.tamper_filter_count == 2'd0)
          tp_evt[i] = (tp_in[i] != s_ff.tp_prev[i]) & (tp_in[i] != s_ff.tp_pol[i]);
        else
          tp_evt[i] = (tp_in[i] == s_ff.tp_pol[i]) & (s_ff.tp_run[i] == need - 4'h1);
      end
    end

    // alarm a compare of the live calendar
    // weekday select reuses the units field and ignores the tens
    match_hour = s_ff.alarm.alarm_hour_mask |
      ({s_ff.alarm.am_pm_flag, s_ff.alarm.hour_t, s_ff.alarm.hour_u} ==
       {cal_time.am_pm_flag, cal_time.hour_t, cal_time.hour_u});
    if (s_ff.alarm.weekday_select)
      match_day = s_ff.alarm.day_units_bcd == {1'b0, cal_date.weekday};
    else
      match_day = {s_ff.alarm.day_tens_bcd, s_ff.alarm.day_units_bcd} ==
        {cal_date.day_t, cal_date.day_u};
    match_day = match_day | s_ff.alarm.alarm_day_mask;
    // minutes and seconds, each with its own mask bit
    match_low = (s_ff.alarm.min_mask |
      ({s_ff.alarm.min_t, s_ff.alarm.min_u} == {cal_time.min_t, cal_time.min_u})) &
      (s_ff.alarm.sec_mask |
      ({s_ff.alarm.sec_t, s_ff.alarm.sec_u} == {cal_time.sec_t, cal_time.sec_u}));
    nxt_s.alarm_hit = match_hour & match_day & match_low;

    // status word as read
    // bits that carry no flag read zero
    st_word = 32'h0000_0000;
    st_word[`RSS_ST_PEND] = s_ff.shift_pending_flag;
    st_word[`RSS_ST_SYNC] = s_ff.shadow_synced_flag;
    st_word[`RSS_ST_TS] = s_ff.stamp_event_flag;
    st_word[`RSS_ST_TSOVR] = s_ff.stamp_overrun;
    st_word[`RSS_ST_TP1 +: 2] = s_ff.tp_flag;

    // register writes, merged per byte lane; clears come before sets below
    // a partial write keeps the untouched lanes at their current value, except the shift word, whose untouched lanes write zero
    wst = (st_word & ~bmask) | (wb_dat_i & bmask);
    if (wr)
    begin
      unique case (wb_adr_i)
        `RSS_OFF_STATUS:
        begin
          // write 0 clears, write 1 leaves alone
          nxt_s.shadow_synced_flag = s_ff.shadow_synced_flag & wst[`RSS_ST_SYNC];
          nxt_s.stamp_event_flag = s_ff.stamp_event_flag & wst[`RSS_ST_TS];
          nxt_s.stamp_overrun = s_ff.stamp_overrun & wst[`RSS_ST_TSOVR];
          nxt_s.tp_flag = s_ff.tp_flag & wst[`RSS_ST_TP1 +: 2];
        end
        // divider takes only its low fifteen bits
        `RSS_OFF_DIVIDER:
          nxt_s.sync_divider_value = 15'(({17'h0_0000, s_ff.sync_divider_value} & ~bmask) |
            (wb_dat_i & bmask));
        // alarm word is kept whole; the compare picks out its fields
        `RSS_OFF_ALARM:
          nxt_s.alarm = (s_ff.alarm & ~bmask) | (wb_dat_i & bmask);
        `RSS_OFF_SHIFT:
        begin
          // the sync flag drops even when a pending shift blocks the new value
          nxt_s.shadow_synced_flag = 1'b0;
          if (!s_ff.shift_pending_flag)
          begin
            nxt_s.fraction_subtract = 15'(wb_dat_i & bmask);
            nxt_s.add_pending = wb_dat_i[`RSS_SH_ADD] & wb_sel_i[3];
            nxt_s.shift_pending_flag = 1'b1;
          end
        end
        `RSS_OFF_CAL:
        begin
          // low count bits are forced to zero for the shorter windows
          wst = (st_word & 32'h0000_0000) | ({16'h0000, s_ff.pulse_insert_enable,
            s_ff.eight_second_cycle, s_ff.sixteen_second_cycle, 4'h0,
            s_ff.suppressed_pulse_count} & ~bmask) | (wb_dat_i & bmask);
          nxt_s.sixteen_second_cycle = wst[`RSS_CAL_C16];
          nxt_s.eight_second_cycle = wst[`RSS_CAL_C8];
          nxt_s.pulse_insert_enable = wst[`RSS_CAL_INS];
          nxt_s.suppressed_pulse_count = wst[8:0];
          if (wst[`RSS_CAL_C16])
            nxt_s.suppressed_pulse_count[0] = 1'b0;
          if (wst[`RSS_CAL_C8])
            nxt_s.suppressed_pulse_count[1:0] = 2'b00;
        end
        `RSS_OFF_TAMPER:
        begin
          // merge over the current configuration, as for the calibration word
          wst = ({19'h0_0000, s_ff.tamper_filter_count, 6'h00, s_ff.tp_pol[1],
            s_ff.tp_en[1], s_ff.tamper_irq_enable, s_ff.tp_pol[0], s_ff.tp_en[0]} & ~bmask) |
            (wb_dat_i & bmask);
          nxt_s.tp_en = {wst[`RSS_TA_EN2], wst[`RSS_TA_EN1]};
          nxt_s.tp_pol = {wst[`RSS_TA_POL2], wst[`RSS_TA_POL1]};
          nxt_s.tamper_irq_enable = wst[`RSS_TA_IE];
          nxt_s.tamper_filter_count = wst[`RSS_TA_FLT +: 2];
        end
        default: ; // key, read-only and unmapped words take no write
      endcase
    end

    // clearing the stamp flag wipes the captures
    // a new event in the same clock refills them just below
    if (!nxt_s.stamp_event_flag)
    begin
      nxt_s.ts_time = '0;
      nxt_s.ts_date = '0;
      nxt_s.ts_frac = 16'h0000;
    end

    // hardware sets win over a software clear in the same cycle
    // a shift accepted in this clock counts as pending, so the copy is not
    // marked synced while the shift is still to be applied
    if (apre_tick & ~s_ff.shift_pending_flag & ~nxt_s.shift_pending_flag)
      nxt_s.shadow_synced_flag = 1'b1;
    if (stamp_trigger)
    begin
      // overrun keeps a clear written in this clock unless the flag was already up
      nxt_s.stamp_overrun = nxt_s.stamp_overrun | s_ff.stamp_event_flag;
      nxt_s.stamp_event_flag = 1'b1;
      nxt_s.ts_time = cal_time;
      nxt_s.ts_date = cal_date;
      nxt_s.ts_frac = s_ff.fraction_counter;
    end
    // tamper flags: a new event beats a clear in the same clock
    nxt_s.tp_flag = nxt_s.tp_flag | tp_evt;
    // the request follows the flags one clock later
    nxt_s.irq = s_ff.tamper_irq_enable & (|s_ff.tp_flag);

    // read mux, registered together with ack
    // the key is taken and thrown away: this block has no write protection,
    // so key and shift words only ever read back as zero
    unique case (wb_adr_i)
      `RSS_OFF_STATUS: rd = st_word;
      `RSS_OFF_DIVIDER: rd = {17'h0_0000, s_ff.sync_divider_value};
      `RSS_OFF_ALARM: rd = s_ff.alarm;
      `RSS_OFF_FRACTION_COUNTER_READOUT: rd = {16'h0000, s_ff.fraction_counter};
      `RSS_OFF_TSTIME: rd = {9'h000, s_ff.ts_time};
      `RSS_OFF_TSDATE: rd = {16'h0000, s_ff.ts_date};
      `RSS_OFF_TSSUB: rd = {16'h0000, s_ff.ts_frac};
      `RSS_OFF_CAL: rd = {16'h0000, s_ff.pulse_insert_enable, s_ff.eight_second_cycle,
        s_ff.sixteen_second_cycle, 4'h0, s_ff.suppressed_pulse_count};
      `RSS_OFF_TAMPER: rd = {19'h0_0000, s_ff.tamper_filter_count, 6'h00, s_ff.tp_pol[1],
        s_ff.tp_en[1], s_ff.tamper_irq_enable, s_ff.tp_pol[0], s_ff.tp_en[0]};
      default: rd = 32'h0000_0000; // key and shift words read zero
    endcase
    // data is zero outside the ack cycle so the bus never shows stale words
    nxt_s.rdat = (take & ~wb_we_i) ? rd : 32'h0000_0000;
  end

  // single state register; async reset loads constants only
  // the divider and async prescaler leave reset at their default division
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_ff <= '0;
      s_ff.sync_divider_value <= `RSS_DIV_RESET;
      s_ff.apre <= `RSS_APRE_RESET;
    end
    else
      s_ff <= nxt_s;
  end

  // outputs straight from the state register
  // so no output carries a combinational path from the bus
  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.rdat;
  assign second_tick = s_ff.sec_tick;
  assign advance_one_second = s_ff.add_sec;
  assign alarm_hit = s_ff.alarm_hit;
  assign tamper_irq = s_ff.irq;

endmodule

// >>> verification/rss_core_asserts.sv
// concurrent checks on the bus and event ports of the shift/stamp/calib block
`timescale 1ns/1ps
module rss_core_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // events
  input wire logic stamp_trigger,
  input wire logic advance_one_second,
  input wire logic alarm_hit,
  input wire logic tamper_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a request is taken on an edge where ack is still low
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  sequence rd_at(logic [7:0] a);
    req && !wb_we_i && wb_adr_i == a;
  endsequence
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (req |=> wb_ack_o)
    else $error("ack did not follow a taken request");
  chk_key_reads_zero: assert property (rd_at(8'h24) |=> wb_dat_o == 32'h0000_0000)
    else $error("key register read not zero");
  chk_shift_reads_zero: assert property (rd_at(8'h2C) |=> wb_dat_o == 32'h0000_0000)
    else $error("shift register read not zero");
  chk_stamp_flag_set: assert property (stamp_trigger ##[1:2] rd_at(8'h0C) |=> wb_dat_o[11])
    else $error("stamp flag not set after event");
  chk_shift_unsyncs: assert property ((req && wb_we_i && wb_adr_i == 8'h2C) ##[1:4]
    rd_at(8'h0C) |=> !wb_dat_o[5])
    else $error("sync flag still set after shift write");
  chk_clear_zeroes: assert property ((req && wb_we_i && wb_adr_i == 8'h0C && wb_sel_i[1]
    && !wb_dat_i[11] && !stamp_trigger) ##1 (!stamp_trigger)[*2] ##1
    (rd_at(8'h30) && !stamp_trigger) |=> wb_dat_o == 32'h0000_0000)
    else $error("stamp time not zero after flag clear");
  chk_cal_sixteen: assert property (rd_at(8'h3C) |=> (wb_dat_o[13] -> !wb_dat_o[0]))
    else $error("count bit 0 set in sixteen second cycle");
  chk_cal_eight: assert property (rd_at(8'h3C) |=> (wb_dat_o[14] -> wb_dat_o[1:0] == 2'b00))
    else $error("count bits 1:0 set in eight second cycle");
  // main scenarios reached
  cov_advance: cover property (advance_one_second);
  cov_alarm: cover property (alarm_hit);
  cov_irq: cover property (tamper_irq);
  cov_stamp_read: cover property (stamp_trigger ##[1:2] rd_at(8'h0C));
endmodule

// >>> verification/tb.sv
// self-checking bench for the shift/stamp/calib block over its register bus
`timescale 1ns/1ps
module tb;
  logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stamp_trigger;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  rss_pkg::rss_time_s cal_time;
  rss_pkg::rss_date_s cal_date;
  logic second_tick, advance_one_second, alarm_hit;
  logic tamper_input_one, tamper_input_two, tamper_irq;
  int fails = 0;
  int checks = 0;
  int adv_cnt = 0;
  logic [7:0] zero_regs[8] = '{8'h24, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h7C};
  rss_core dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cal_time, .cal_date, .stamp_trigger, .second_tick,
    .advance_one_second, .alarm_hit, .tamper_input_one, .tamper_input_two, .tamper_irq);
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count calendar advance pulses
  always @(posedge clk)
    if (advance_one_second === 1'b1) adv_cnt++;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled high, never assumes latency
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20) fails++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(nm, q, exp);
  endtask
  task automatic rbit(input string nm, input logic [7:0] a, input int b, input logic e);
    xfer(1'b0, a, 32'h0000_0000);
    check(nm, {31'b0, q[b]}, {31'b0, e});
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, far beyond the several hundred cycles the tests need
  initial
  begin
    #400000;
    fails++;
    summarize();
  end
  initial
  begin
    int k;
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, stamp_trigger} = '0;
    {tamper_input_one, tamper_input_two} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    cal_time = '0;
    cal_date = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (zero_regs[i]) rd("reset value", zero_regs[i], 32'h0000_0000);
    rd("divider reset", 8'h10, 32'h0000_00FF);
    $display("test reset values done");
    xfer(1'b1, 8'h24, 32'h0000_CAFE);
    rd("key readback", 8'h24, 32'h0000_0000);
    xfer(1'b1, 8'h3C, 32'h0000_81FF);
    rd("cal plain", 8'h3C, 32'h0000_81FF);
    xfer(1'b1, 8'h3C, 32'h0000_21FF);
    rd("cal sixteen", 8'h3C, 32'h0000_21FE);
    xfer(1'b1, 8'h3C, 32'h0000_41FF);
    rd("cal eight", 8'h3C, 32'h0000_41FC);
    $display("test key and calibration done");
    // the advance pulse marks a prescaler tick, so the next shift stays pending a while
    xfer(1'b1, 8'h2C, 32'h8000_0200);
    k = 0;
    while (advance_one_second !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 300) fails++;
    // the counter sat at zero since reset, so this tick also reloads it
    check("second tick", {31'b0, second_tick}, 32'h0000_0001);
    xfer(1'b0, 8'h28, 32'h0000_0000);
    check("fraction_counter_readout above divider", {31'b0, q[15:0] > 16'h00FF}, 32'h0000_0001);
    xfer(1'b1, 8'h2C, 32'h0000_0010);
    rbit("shift pending", 8'h0C, 3, 1'b1);
    rbit("sync cleared", 8'h0C, 5, 1'b0);
    xfer(1'b1, 8'h2C, 32'h8000_0001);
    k = 0;
    do
    begin
      xfer(1'b0, 8'h0C, 32'h0000_0000);
      k++;
    end
    while (q[5] !== 1'b1 && k < 200);
    check("sync restored", {31'b0, q[5]}, 32'h0000_0001);
    check("advance count", adv_cnt, 32'h0000_0001);
    $display("test shift done");
    cal_time <= 23'h51_3456;
    cal_date <= 16'h7225;
    stamp_trigger <= 1'b1;
    @(posedge clk);
    stamp_trigger <= 1'b0;
    rd("stamp time", 8'h30, 32'h0051_3456);
    rd("stamp date", 8'h34, 32'h0000_7225);
    rbit("stamp flag", 8'h0C, 11, 1'b1);
    stamp_trigger <= 1'b1;
    @(posedge clk);
    stamp_trigger <= 1'b0;
    rbit("stamp overrun", 8'h0C, 12, 1'b1);
    xfer(1'b1, 8'h0C, 32'h0000_0000);
    for (int i = 2; i < 5; i++) rd("stamp cleared", zero_regs[i], 32'h0000_0000);
    $display("test timestamp done");
    xfer(1'b1, 8'h40, 32'h0000_0001);
    tamper_input_one <= 1'b1;
    repeat (3) @(posedge clk);
    rbit("tamper one edge", 8'h0C, 13, 1'b1);
    check("irq masked", {31'b0, tamper_irq}, 32'h0000_0000);
    xfer(1'b1, 8'h40, 32'h0000_0005);
    repeat (2) @(posedge clk);
    check("irq enabled", {31'b0, tamper_irq}, 32'h0000_0001);
    tamper_input_one <= 1'b0;
    xfer(1'b1, 8'h40, 32'h0000_0818);
    xfer(1'b1, 8'h0C, 32'h0000_0000);
    tamper_input_two <= 1'b1;
    @(posedge clk);
    tamper_input_two <= 1'b0;
    repeat (3) @(posedge clk);
    rbit("tamper two short", 8'h0C, 14, 1'b0);
    tamper_input_two <= 1'b1;
    repeat (4) @(posedge clk);
    rbit("tamper two level", 8'h0C, 14, 1'b1);
    $display("test tamper done");
    xfer(1'b1, 8'h1C, 32'h7351_8080);
    repeat (2) @(posedge clk);
    check("alarm weekday pm", {31'b0, alarm_hit}, 32'h0000_0001);
    cal_time.am_pm_flag <= 1'b0;
    repeat (3) @(posedge clk);
    check("alarm am mismatch", {31'b0, alarm_hit}, 32'h0000_0000);
    xfer(1'b1, 8'h1C, 32'h73D1_8080);
    repeat (2) @(posedge clk);
    check("alarm hour masked", {31'b0, alarm_hit}, 32'h0000_0001);
    cal_date.weekday <= 3'h4;
    repeat (3) @(posedge clk);
    check("alarm weekday miss", {31'b0, alarm_hit}, 32'h0000_0000);
    xfer(1'b1, 8'h1C, 32'hF3D1_8080);
    repeat (2) @(posedge clk);
    check("alarm day masked", {31'b0, alarm_hit}, 32'h0000_0001);
    $display("test alarm done");
    summarize();
  end
endmodule
bind rss_core rss_core_asserts u_chk (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stamp_trigger,
  .advance_one_second, .alarm_hit, .tamper_irq);
